/* hw/tmr16_consts.svh */
// Constants for the 16-bit timer output, prescaler and pulse generator block
// How it works
// - With both edges on first input, the reverse-phase capture never fires.
// - Output control bit 4 set: second compare match toggles output flip-flop.
// - Output control bit 1 set: first compare match toggles output flip-flop.
// - Command field 3:2: 00 hold, 01 clear, 10 set; 11 forbidden.
// - Set and clear command bits always read back as zero.
// - Output enable bit 0 low forces timer output low, else follows flip-flop.
// - Prescaler bits 7:6 pick second input edge: 00 fall, 01 rise, 11 both.
// - Prescaler bits 5:4 pick first input edge: 00 fall, 01 rise, 11 both.
// - Prescaler bits 1:0 pick count clock: clk, clk/4, clk/64, first input edge.
// - Input high after reset gives a rising edge on first start only.
// - Port direction bit 0 drives pin, 1 makes it input; resets all ones.
// - Interval mode: match on first compare clears counter and raises request.
// - Interval equals compare value plus one count clocks.
// - Pulse mode: first compare sets period, second sets pulse width.
// - Period is first compare plus one; high time second compare plus one.
// - Mode bits 3:2: stop and clear, free run, edge restart, match restart.
// - Counter is read-only; a read briefly holds the count clock.
`ifndef TMR16_CONSTS_SVH
`define TMR16_CONSTS_SVH
`define TMR16_AW 18
`define TMR16_IDX_MODE 16'hFF60
`define TMR16_IDX_PRE 16'hFF61
`define TMR16_IDX_CRC 16'hFF62
`define TMR16_IDX_TOC 16'hFF63
`define TMR16_IDX_P3 16'hFF64
`define TMR16_IDX_CR0 16'hFF65
`define TMR16_IDX_CR1 16'hFF66
`define TMR16_IDX_CNT 16'hFF67
`define TMR16_RST_BYTE 8'h00
`define TMR16_RST_P3 8'hFF
`define TMR16_P3_FIXED 2'h3
`define TMR16_OVF 0
`define TMR16_TOE 0
`define TMR16_TOG1 1
`define TMR16_TOG2 4
`define TMR16_CRC_CAP0 0
`define TMR16_CRC_TRIG 1
`define TMR16_CRC_CAP1 2
`define TMR16_CMD_CLR 2'h1
`define TMR16_CMD_SET 2'h2
`define TMR16_EDGE_FALL 2'h0
`define TMR16_EDGE_RISE 2'h1
`define TMR16_EDGE_BOTH 2'h3
`define TMR16_DIV4_MASK 6'h03
`define TMR16_DIV64_MASK 6'h3F
`define TMR16_CNT_MAX 16'hFFFF
`define TMR16_RESP_OK 2'h0
`define TMR16_RESP_ERR 2'h2
`endif

/* hw/tmr16_pkg.sv */
// Types shared by the timer block
package tmr16_pkg;
  typedef enum logic [1:0] {MODE_STOP, MODE_FREE, MODE_EDGE, MODE_MATCH} tmr16_mode_e;
  typedef struct packed {
    logic [17:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
  } tmr16_wr_s;
  typedef struct packed {
    logic awready;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
  } tmr16_wrsp_s;
  typedef struct packed {
    logic [17:0] araddr;
    logic arvalid;
    logic rready;
  } tmr16_rd_s;
  typedef struct packed {
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
  } tmr16_rrsp_s;
endpackage

/* hw/tmr16_edge.sv */
// Timer input synchroniser and valid edge detector
`include "tmr16_consts.svh"
module tmr16_edge (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic pin,
  input wire logic run,
  input wire logic [1:0] sel,
  output logic valid_edge,
  output logic rev_edge
);
  logic [2:0] s_q, s_d;
  logic level_q, level_d, prev_q, prev_d, seen_q, seen_d;
  logic valid_d, rev_d, track, rise, fall;

  // Three-stage sync, level taken once stages two and three agree
  always_comb
  begin
    s_d = {s_q[1:0], pin};
    level_d = (s_q[1] == s_q[2]) ? s_q[2] : level_q;
    track = run || seen_q;
    // History frozen at zero until the first start, so a high pin shows as a rise
    prev_d = track ? level_q : prev_q;
    seen_d = seen_q || run;
    rise = track && level_q && !prev_q;
    fall = track && !level_q && prev_q;
    case (sel)
      `TMR16_EDGE_FALL:
      begin
        valid_d = fall;
        rev_d = rise;
      end
      `TMR16_EDGE_RISE:
      begin
        valid_d = rise;
        rev_d = fall;
      end
      `TMR16_EDGE_BOTH:
      begin
        valid_d = rise || fall;
        rev_d = 1'b0;
      end
      default:
      begin
        valid_d = 1'b0;
        rev_d = 1'b0;
      end
    endcase
  end

  // State registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_q <= 3'h0;
      level_q <= 1'b0;
      prev_q <= 1'b0;
      seen_q <= 1'b0;
      valid_edge <= 1'b0;
      rev_edge <= 1'b0;
    end
    else
    begin
      s_q <= s_d;
      level_q <= level_d;
      prev_q <= prev_d;
      seen_q <= seen_d;
      valid_edge <= valid_d;
      rev_edge <= rev_d;
    end
  end

  a_both_no_rev: assert property (@(posedge aclk) disable iff (!aresetn)
    sel == `TMR16_EDGE_BOTH |=> !rev_edge) else $error("reverse edge with both edges selected");
  a_first_start_rise: assert property (@(posedge aclk) disable iff (!aresetn)
    (!seen_q && run && level_q && sel == `TMR16_EDGE_RISE) |=> valid_edge)
    else $error("no rising edge on first start with high input");
endmodule

/* hw/tmr16_top.sv */
// Timer counter with output control, prescaler, port direction and AXI4-Lite registers
`include "tmr16_consts.svh"
module tmr16_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire tmr16_pkg::tmr16_wr_s wr_req,
  output tmr16_pkg::tmr16_wrsp_s wr_rsp,
  input wire tmr16_pkg::tmr16_rd_s rd_req,
  output tmr16_pkg::tmr16_rrsp_s rd_rsp,
  input wire logic first_timer_input,
  input wire logic second_timer_input,
  output logic timer_output_pin,
  output logic first_match_irq,
  output logic second_match_irq,
  output logic [5:0] port3_out_en
);
  import tmr16_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Declarations
  tmr16_wrsp_s wr_rsp_q, wr_rsp_d;
  tmr16_rrsp_s rd_rsp_q, rd_rsp_d;
  logic wr_fire, rd_fire, rd_cnt, wr_hit, rd_hit;
  logic [15:0] widx, ridx;
  logic [31:0] rdat;
  logic [1:0] mode_q, mode_d;
  logic ovf_q, ovf_d;
  logic [7:0] prm_q, prm_d, toc_q, toc_d, p3_q, p3_d;
  logic [2:0] crc_q, crc_d;
  logic [15:0] cnt_q, cnt_d, cr0_q, cr0_d, cr1_q, cr1_d;
  logic [5:0] pre_q, pre_d, p3oe_d;
  logic pend_q, pend_d, ff_q, ff_d, out_d, irq0_d, irq1_d;
  logic [1:0] cmd;
  logic run, tick_raw, tick, m0, m1, cap0, cap1, wlane0, wlane1;
  logic [1:0] pins, vedge, redge;
  logic [1:0][1:0] esel;
  tmr16_mode_e mode;

  assign wr_rsp = wr_rsp_q;
  assign rd_rsp = rd_rsp_q;

  ////////////////////////////////////////////////////////////////////////
  // Input edge detectors, first and second timer input
  assign pins = {second_timer_input, first_timer_input};
  assign esel = {prm_q[7:6], prm_q[5:4]};

  generate
    for (genvar i = 0; i < 2; i++)
    begin : g_edge
      tmr16_edge u_edge (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin(pins[i]),
        .run(run),
        .sel(esel[i]),
        .valid_edge(vedge[i]),
        .rev_edge(redge[i])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Bus slave: address and data taken together, answer one cycle later
  always_comb
  begin
    wr_rsp_d = wr_rsp_q;
    rd_rsp_d = rd_rsp_q;
    widx = wr_req.awaddr[17:2];
    ridx = rd_req.araddr[17:2];
    wr_fire = wr_rsp_q.awready;
    rd_fire = rd_rsp_q.arready;
    wr_hit = (widx >= `TMR16_IDX_MODE) && (widx <= `TMR16_IDX_CNT);
    rd_hit = (ridx >= `TMR16_IDX_MODE) && (ridx <= `TMR16_IDX_CNT);
    wr_rsp_d.awready = wr_req.awvalid && wr_req.wvalid && !wr_rsp_q.awready && !wr_rsp_q.bvalid;
    wr_rsp_d.wready = wr_rsp_d.awready;
    if (wr_fire)
    begin
      wr_rsp_d.bvalid = 1'b1;
      wr_rsp_d.bresp = wr_hit ? `TMR16_RESP_OK : `TMR16_RESP_ERR;
    end
    else if (wr_req.bready)
    begin
      wr_rsp_d.bvalid = 1'b0;
    end
    rd_rsp_d.arready = rd_req.arvalid && !rd_rsp_q.arready && !rd_rsp_q.rvalid;
    case (ridx)
      `TMR16_IDX_MODE: rdat = {28'h0, mode_q, 1'b0, ovf_q};
      `TMR16_IDX_PRE: rdat = {24'h0, prm_q};
      `TMR16_IDX_CRC: rdat = {29'h0, crc_q};
      `TMR16_IDX_TOC: rdat = {24'h0, toc_q};
      `TMR16_IDX_P3: rdat = {24'h0, p3_q};
      `TMR16_IDX_CR0: rdat = {16'h0, cr0_q};
      `TMR16_IDX_CR1: rdat = {16'h0, cr1_q};
      `TMR16_IDX_CNT: rdat = {16'h0, cnt_q};
      default: rdat = 32'h0;
    endcase
    if (rd_fire)
    begin
      rd_rsp_d.rvalid = 1'b1;
      rd_rsp_d.rdata = rdat;
      rd_rsp_d.rresp = rd_hit ? `TMR16_RESP_OK : `TMR16_RESP_ERR;
    end
    else if (rd_req.rready)
    begin
      rd_rsp_d.rvalid = 1'b0;
    end
  end

  // Bus registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wr_rsp_q <= '0;
      rd_rsp_q <= '0;
    end
    else
    begin
      wr_rsp_q <= wr_rsp_d;
      rd_rsp_q <= rd_rsp_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Counter, compare, capture, output flip-flop and control registers
  always_comb
  begin
    mode = tmr16_mode_e'(mode_q);
    run = mode != MODE_STOP;
    wlane0 = wr_fire && wr_req.wstrb[0];
    wlane1 = wr_fire && wr_req.wstrb[1];
    mode_d = mode_q;
    ovf_d = ovf_q;
    prm_d = prm_q;
    crc_d = crc_q;
    toc_d = toc_q;
    p3_d = p3_q;
    cr0_d = cr0_q;
    cr1_d = cr1_q;
    cmd = 2'h0;
    // Software writes, byte lane 0 for the 8-bit registers
    if (wlane0)
    begin
      case (widx)
        `TMR16_IDX_MODE:
        begin
          mode_d = wr_req.wdata[3:2];
          ovf_d = ovf_q && wr_req.wdata[`TMR16_OVF];
        end
        `TMR16_IDX_PRE: prm_d = {wr_req.wdata[7:4], 2'h0, wr_req.wdata[1:0]};
        `TMR16_IDX_CRC: crc_d = wr_req.wdata[2:0];
        `TMR16_IDX_TOC:
        begin
          // Command bits act once and are never stored
          toc_d = {3'h0, wr_req.wdata[4], 2'h0, wr_req.wdata[1:0]};
          cmd = wr_req.wdata[3:2];
        end
        `TMR16_IDX_P3: p3_d = {`TMR16_P3_FIXED, wr_req.wdata[5:0]};
        `TMR16_IDX_CR0: cr0_d[7:0] = wr_req.wdata[7:0];
        `TMR16_IDX_CR1: cr1_d[7:0] = wr_req.wdata[7:0];
        default: cmd = 2'h0;
      endcase
    end
    if (wlane1 && widx == `TMR16_IDX_CR0)
    begin
      cr0_d[15:8] = wr_req.wdata[15:8];
    end
    if (wlane1 && widx == `TMR16_IDX_CR1)
    begin
      cr1_d[15:8] = wr_req.wdata[15:8];
    end
    // Prescaler and count clock choice
    pre_d = pre_q + 6'h01;
    case (prm_q[1:0])
      2'h0: tick_raw = 1'b1;
      2'h1: tick_raw = (pre_q & `TMR16_DIV4_MASK) == `TMR16_DIV4_MASK;
      2'h2: tick_raw = (pre_q & `TMR16_DIV64_MASK) == `TMR16_DIV64_MASK;
      default: tick_raw = vedge[0];
    endcase
    // A counter read defers a pending tick by one cycle
    rd_cnt = rd_fire && ridx == `TMR16_IDX_CNT;
    tick = run && (tick_raw || pend_q) && !rd_cnt;
    pend_d = run && rd_cnt && (tick_raw || pend_q);
    // Compare matches on the count clock edge
    m0 = tick && cnt_q == cr0_q && !crc_q[`TMR16_CRC_CAP0];
    m1 = tick && cnt_q == cr1_q && !crc_q[`TMR16_CRC_CAP1];
    // Captures: CR0 on reverse phase of first input or valid edge of second input, CR1 on valid edge of first input
    cap0 = run && crc_q[`TMR16_CRC_CAP0] && (crc_q[`TMR16_CRC_TRIG] ? redge[0] : vedge[1]);
    cap1 = run && crc_q[`TMR16_CRC_CAP1] && vedge[0];
    if (cap0)
    begin
      cr0_d = cnt_q;
    end
    if (cap1)
    begin
      cr1_d = cnt_q;
    end
    // Counter next value
    cnt_d = cnt_q;
    if (!run)
    begin
      cnt_d = 16'h0000;
    end
    else if (mode == MODE_EDGE && vedge[0])
    begin
      cnt_d = 16'h0000;
    end
    else if (tick)
    begin
      cnt_d = (mode == MODE_MATCH && m0) ? 16'h0000 : cnt_q + 16'h0001;
      if (cnt_q == `TMR16_CNT_MAX)
      begin
        ovf_d = 1'b1;
      end
    end
    irq0_d = m0 || cap0;
    irq1_d = m1 || cap1;
    // Output flip-flop: command first, else toggles on matches
    if (cmd == `TMR16_CMD_CLR)
    begin
      ff_d = 1'b0;
    end
    else if (cmd == `TMR16_CMD_SET)
    begin
      ff_d = 1'b1;
    end
    else
    begin
      ff_d = ff_q ^ (m0 && toc_q[`TMR16_TOG1]) ^ (m1 && toc_q[`TMR16_TOG2]);
    end
    out_d = toc_d[`TMR16_TOE] && ff_d;
    p3oe_d = ~p3_d[5:0];
  end

  // Core registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      mode_q <= 2'h0;
      ovf_q <= 1'b0;
      prm_q <= `TMR16_RST_BYTE;
      crc_q <= 3'h0;
      toc_q <= `TMR16_RST_BYTE;
      p3_q <= `TMR16_RST_P3;
      cr0_q <= 16'h0000;
      cr1_q <= 16'h0000;
      cnt_q <= 16'h0000;
      pre_q <= 6'h00;
      pend_q <= 1'b0;
      ff_q <= 1'b0;
      timer_output_pin <= 1'b0;
      first_match_irq <= 1'b0;
      second_match_irq <= 1'b0;
      port3_out_en <= 6'h00;
    end
    else
    begin
      mode_q <= mode_d;
      ovf_q <= ovf_d;
      prm_q <= prm_d;
      crc_q <= crc_d;
      toc_q <= toc_d;
      p3_q <= p3_d;
      cr0_q <= cr0_d;
      cr1_q <= cr1_d;
      cnt_q <= cnt_d;
      pre_q <= pre_d;
      pend_q <= pend_d;
      ff_q <= ff_d;
      timer_output_pin <= out_d;
      first_match_irq <= irq0_d;
      second_match_irq <= irq1_d;
      port3_out_en <= p3oe_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  a_stop_clears: assert property (@(posedge aclk) disable iff (!aresetn)
    mode_q == 2'h0 |=> cnt_q == 16'h0000) else $error("counter not cleared in stop mode");
  a_interval_wrap: assert property (@(posedge aclk) disable iff (!aresetn)
    (mode_q == 2'h3 && m0) |=> (cnt_q == 16'h0000 && first_match_irq))
    else $error("interval match did not clear and request");
  a_toggle_first: assert property (@(posedge aclk) disable iff (!aresetn)
    (m0 && !m1 && toc_q[1] && cmd == 2'h0) |=> (ff_q != $past(ff_q) && first_match_irq))
    else $error("first match did not toggle");
  a_toggle_second: assert property (@(posedge aclk) disable iff (!aresetn)
    (m1 && !m0 && toc_q[4] && cmd == 2'h0) |=> (ff_q != $past(ff_q) && second_match_irq))
    else $error("second match did not toggle");
  a_set_cmd: assert property (@(posedge aclk) disable iff (!aresetn)
    (cmd == 2'h2) |=> (ff_q && toc_q[3:2] == 2'h0)) else $error("set command failed");
  a_out_gated: assert property (@(posedge aclk) disable iff (!aresetn)
    timer_output_pin == (toc_q[0] && ff_q)) else $error("timer output not gated by enable");
  a_div4_spacing: assert property (@(posedge aclk) disable iff (!aresetn)
    (prm_q[1:0] == 2'h1 && tick_raw && $stable(prm_q)) |=> (!tick_raw)[*3])
    else $error("divide by four tick spacing wrong");
  a_read_holds: assert property (@(posedge aclk) disable iff (!aresetn)
    (rd_cnt && run && !(mode_q == 2'h2 && vedge[0])) |=> cnt_q == $past(cnt_q))
    else $error("counter moved during read");
  a_port_dir: assert property (@(posedge aclk) disable iff (!aresetn)
    port3_out_en == ~p3_q[5:0]) else $error("port enable disagrees with direction");
endmodule

/* test/tmr16_pins.sv */
// Model of the external pulse sources on the two timer input pins
module tmr16_pins (
  input wire logic aclk,
  input wire logic timer_output_pin,
  output logic first_timer_input,
  output logic second_timer_input
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int MIN_W = 20;
  // Both pins idle low, so no edge is seen on the first start
  initial
  begin
    first_timer_input = 1'b0;
    second_timer_input = 1'b0;
  end
  // One high pulse on the chosen pin, never shorter than the sampling window
  task automatic pulse(input bit which, input int w);
    int n;
    n = (w < MIN_W) ? MIN_W : w;
    @(posedge aclk);
    if (which)
      second_timer_input <= 1'b1;
    else
      first_timer_input <= 1'b1;
    repeat (n) @(posedge aclk);
    first_timer_input <= 1'b0;
    second_timer_input <= 1'b0;
    repeat (n) @(posedge aclk);
  endtask
  // Static level on the first input, for a start with the pin already high
  task automatic level(input logic lvl);
    first_timer_input <= lvl;
  endtask
endmodule

/* test/test_timer16_output_prescaler_ppg.sv */
// Self-checking bench for the timer output, prescaler and pulse generator block
`include "tmr16_consts.svh"
module test_timer16_output_prescaler_ppg import tmr16_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic aclk;
  logic aresetn;
  tmr16_wr_s wr_req;
  tmr16_wrsp_s wr_rsp;
  tmr16_rd_s rd_req;
  tmr16_rrsp_s rd_rsp;
  logic first_timer_input, second_timer_input, timer_output_pin;
  logic first_match_irq, second_match_irq;
  logic [5:0] port3_out_en;
  logic lp;
  int bad_count, checks, cyc, n0, n1, last0, gap0, tp, hi, lo;
  logic [7:0] tw[4] = '{8'h09, 8'h05, 8'h08, 8'h01};
  logic tpin[4] = '{1'b1, 1'b0, 1'b0, 1'b1};
  logic [7:0] ep[7] = '{8'h03, 8'h13, 8'h33, 8'h00, 8'h40, 8'hC0, 8'h30};
  logic [2:0] ec[7] = '{3'h0, 3'h0, 3'h0, 3'h1, 3'h1, 3'h1, 3'h3};

  tmr16_top dut (.aclk, .aresetn, .wr_req, .wr_rsp, .rd_req, .rd_rsp, .first_timer_input,
    .second_timer_input, .timer_output_pin, .first_match_irq, .second_match_irq, .port3_out_en);
  tmr16_pins pins (.aclk, .timer_output_pin, .first_timer_input, .second_timer_input);

  ////////////////////////////////////////////////////////////////////////////
  // Clock, and cycle stamps of match pulses and output pin phases
  initial
  begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  always @(posedge aclk)
  begin
    cyc++;
    if (first_match_irq === 1'b1)
    begin
      n0++;
      gap0 = cyc - last0;
      last0 = cyc;
    end
    if (second_match_irq === 1'b1)
      n1++;
    if (timer_output_pin !== lp)
    begin
      if (lp === 1'b1)
        hi = cyc - tp;
      else
        lo = cyc - tp;
      tp = cyc;
      lp = timer_output_pin;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Comparison, verdict and expectations
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("BAD %0t %s got %0h want %0h", $time, what, got, exp);
    end
  endtask
  task automatic finish_test;
    if (bad_count == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  function automatic int div(input int s);
    return s == 0 ? 1 : (s == 1 ? 4 : 64);
  endfunction
  function automatic int exp_edges(input logic [7:0] p, input logic [2:0] c);
    if (p[1:0] == 2'h3)
      return p[5:4] == 2'h3 ? 2 : 1;
    if (c[1])
      return p[5:4] == 2'h3 ? 0 : 1;
    return p[7:6] == 2'h3 ? 2 : 1;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Register bus master; each channel held until its own handshake
  task automatic wreg(input logic [15:0] idx, input logic [31:0] d);
    bit aw, w, b;
    int t;
    @(posedge aclk);
    wr_req.awaddr <= {idx, 2'b00};
    wr_req.wdata <= d;
    wr_req.wstrb <= 4'hF;
    wr_req.awvalid <= 1'b1;
    wr_req.wvalid <= 1'b1;
    wr_req.bready <= 1'b1;
    aw = 1;
    w = 1;
    b = 1;
    t = 0;
    while ((aw || w || b) && t++ < 99)
    begin
      @(posedge aclk);
      if (aw && wr_rsp.awready)
      begin
        wr_req.awvalid <= 1'b0;
        aw = 0;
      end
      if (w && wr_rsp.wready)
      begin
        wr_req.wvalid <= 1'b0;
        w = 0;
      end
      if (b && wr_rsp.bvalid)
      begin
        wr_req.bready <= 1'b0;
        b = 0;
        chk({30'h0, wr_rsp.bresp}, 32'h0, "write response");
      end
    end
    if (aw || w || b)
    begin
      bad_count++;
      $display("BAD %0t write handshake timed out", $time);
    end
  endtask
  task automatic rd(input logic [15:0] idx, output logic [31:0] d, output logic [1:0] r);
    bit a, v;
    int t;
    @(posedge aclk);
    rd_req.araddr <= {idx, 2'b00};
    rd_req.arvalid <= 1'b1;
    rd_req.rready <= 1'b1;
    a = 1;
    v = 1;
    t = 0;
    while ((a || v) && t++ < 99)
    begin
      @(posedge aclk);
      if (a && rd_rsp.arready)
      begin
        rd_req.arvalid <= 1'b0;
        a = 0;
      end
      if (v && rd_rsp.rvalid)
      begin
        rd_req.rready <= 1'b0;
        v = 0;
        d = rd_rsp.rdata;
        r = rd_rsp.rresp;
      end
    end
    if (a || v)
    begin
      bad_count++;
      $display("BAD %0t read handshake timed out", $time);
    end
  endtask
  task automatic rchk(input logic [15:0] idx, input logic [31:0] exp, input string what);
    logic [31:0] d;
    logic [1:0] r;
    rd(idx, d, r);
    chk({30'h0, r}, 32'h0, "read response");
    chk(d, exp, what);
  endtask
  task automatic wait_irq(input int k);
    int b;
    b = n0;
    for (int t = 0; t < 6000 && n0 < b + k; t++)
      @(posedge aclk);
    if (n0 < b + k)
    begin
      bad_count++;
      $display("BAD %0t match requests missing", $time);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    logic [31:0] d;
    logic [1:0] r;
    int n, m, v, b;
    wr_req = '0;
    rd_req = '0;
    aresetn = 1'b0;
    v = $urandom(32'h11FAD481);
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rchk(`TMR16_IDX_PRE, 32'h0, "prescaler reset");
    rchk(`TMR16_IDX_TOC, 32'h0, "output control reset");
    rchk(`TMR16_IDX_P3, 32'hFF, "direction reset");
    chk({26'h0, port3_out_en}, 32'h0, "drive after reset");
    v = $urandom_range(63);
    wreg(`TMR16_IDX_P3, v);
    repeat (2) @(posedge aclk);
    chk({26'h0, port3_out_en}, ~v & 32'h3F, "pin drive");
    rchk(`TMR16_IDX_P3, v | 32'hC0, "direction readback");
    rd(16'hFF68, d, r);
    chk({30'h0, r}, {30'h0, `TMR16_RESP_ERR}, "unmapped response");
    chk(d, 32'h0, "unmapped data");
    // Output flip-flop commands and enable
    foreach (tw[i])
    begin
      wreg(`TMR16_IDX_TOC, tw[i]);
      repeat (2) @(posedge aclk);
      chk(timer_output_pin, tpin[i], "output pin");
      rchk(`TMR16_IDX_TOC, tw[i] & 8'hF3, "command readback");
    end
    // First start with the first input already high counts one rise, a restart none
    pins.level(1'b1);
    wreg(`TMR16_IDX_PRE, 32'h13);
    wreg(`TMR16_IDX_MODE, 32'h04);
    repeat (10) @(posedge aclk);
    rchk(`TMR16_IDX_CNT, 32'h1, "first start rise");
    wreg(`TMR16_IDX_MODE, 32'h0);
    wreg(`TMR16_IDX_MODE, 32'h04);
    repeat (10) @(posedge aclk);
    rchk(`TMR16_IDX_CNT, 32'h0, "restart without rise");
    wreg(`TMR16_IDX_MODE, 32'h0);
    pins.level(1'b0);
    // Interval timer on each divided count clock, toggling on first match
    wreg(`TMR16_IDX_TOC, 32'h03);
    for (int s = 0; s < 3; s++)
    begin
      n = $urandom_range(20, 3);
      wreg(`TMR16_IDX_CR0, n);
      wreg(`TMR16_IDX_PRE, s);
      wreg(`TMR16_IDX_MODE, 32'h0C);
      wait_irq(4);
      chk(gap0, (n + 1) * div(s), "interval");
      chk(hi, (n + 1) * div(s), "toggle period");
      wreg(`TMR16_IDX_MODE, 32'h0);
    end
    rchk(`TMR16_IDX_CNT, 32'h0, "stopped count");
    // Pulse generator: period from first compare, width from second
    m = $urandom_range(8, 1);
    n = m + $urandom_range(10, 2);
    wreg(`TMR16_IDX_CR0, n);
    wreg(`TMR16_IDX_CR1, m);
    wreg(`TMR16_IDX_PRE, 32'h0);
    wreg(`TMR16_IDX_TOC, 32'h1B);
    b = n1;
    wreg(`TMR16_IDX_MODE, 32'h0C);
    wait_irq(4);
    chk(hi, m + 1, "pulse width");
    chk(hi + lo, n + 1, "pulse period");
    chk(n1 - b, 4, "second match count");
    wreg(`TMR16_IDX_MODE, 32'h0);
    // Valid edges as count clock and as capture trigger
    foreach (ep[i])
    begin
      wreg(`TMR16_IDX_PRE, ep[i]);
      wreg(`TMR16_IDX_CRC, ec[i]);
      b = n0;
      wreg(`TMR16_IDX_MODE, 32'h04);
      pins.pulse(ep[i][1:0] != 2'h3 && !ec[i][1], $urandom_range(30, 20));
      repeat (10) @(posedge aclk);
      if (ep[i][1:0] == 2'h3)
        rchk(`TMR16_IDX_CNT, exp_edges(ep[i], ec[i]), "edge count");
      else
        chk(n0 - b, exp_edges(ep[i], ec[i]), "capture count");
      wreg(`TMR16_IDX_MODE, 32'h0);
    end
    // Restart on a rising first input edge clears the running count
    wreg(`TMR16_IDX_CRC, 32'h0);
    wreg(`TMR16_IDX_PRE, 32'h10);
    wreg(`TMR16_IDX_MODE, 32'h08);
    repeat (200) @(posedge aclk);
    pins.pulse(1'b0, 20);
    rd(`TMR16_IDX_CNT, d, r);
    chk({30'h0, r}, 32'h0, "read response");
    chk(d > 32'h1E && d < 32'h28, 1'b1, "edge restart count");
    wreg(`TMR16_IDX_MODE, 32'h0);
    finish_test();
  end

  // Watchdog well beyond the expected run length
  initial
  begin
    #2000000;
    bad_count++;
    finish_test();
  end
endmodule
